// file: src/bbc_duty_meter.sv
// pwm input duty meter: high time over a fixed window becomes a code
`timescale 1ns/100ps
`default_nettype none
module bbc_duty_meter
  import bbc_pkg::*;
#(
  parameter int P_SHIFT = DUTY_WIN_LOG2
)(
  input  wire logic        i_mclk,
  input  wire logic        i_reset,
  input  wire logic        i_run,
  input  wire logic        i_pwm,
  output logic      [11:0] o_code
);
  logic [14:0] win_ff;
  logic [14:0] high_ff;
  wire         win_last = (win_ff == 15'((1 << P_SHIFT) - 1));
  wire  [15:0] high_all = {1'b0, high_ff} + {15'h0000, i_pwm};
  wire  [31:0] scaled   = (32'(high_all) << PWM_CODE_BITS) >> P_SHIFT;

  // window free-runs; code updates once per window, so it lags by one window
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      win_ff  <= '0;
      high_ff <= '0;
      o_code  <= '0;
    end
    else if (!i_run)
    begin
      win_ff  <= '0;
      high_ff <= '0;
      o_code  <= '0;
    end
    else
    begin
      win_ff  <= win_last ? '0 : win_ff + 15'h0001;
      high_ff <= win_last ? '0 : high_all[14:0];
      if (win_last)
        o_code <= scaled[11:0];
    end
  end
endmodule
`default_nettype wire

// file: src/bbc_pin_sync.sv
// three-stage synchroniser with agreement filter for the external pins
`timescale 1ns/100ps
`default_nettype none
module bbc_pin_sync
  import bbc_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_reset,
  input  wire logic [3:0] i_pins,
  output logic      [3:0] o_pins
);
  logic [3:0] s1_ff;
  logic [3:0] s2_ff;
  logic [3:0] s3_ff;
  wire  [3:0] agree = ~(s2_ff ^ s3_ff);

  // a change counts only once stages two and three agree
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      s1_ff  <= PIN_RST;
      s2_ff  <= PIN_RST;
      s3_ff  <= PIN_RST;
      o_pins <= PIN_RST;
    end
    else
    begin
      s1_ff  <= i_pins;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      o_pins <= (agree & s3_ff) | (~agree & o_pins);
    end
  end
endmodule
`default_nettype wire

// file: src/bbc_pkg.sv
// constants, register map and types for the backlight brightness control block
package bbc_pkg;
  localparam logic [6:0] DEV_ADDR        = 7'h36; // arbitrary bus address
  localparam logic [7:0] ADDR_SOFT_RESET = 8'h01;
  localparam logic [7:0] ADDR_ENABLE     = 8'h10;
  localparam logic [7:0] ADDR_SETUP      = 8'h11;
  localparam logic [7:0] ADDR_UPPER      = 8'h19;
  localparam logic [7:0] ADDR_LOWER      = 8'h1a;
  localparam logic [7:0] ADDR_FULL_SCALE = 8'h1b;
  localparam logic [7:0] ADDR_FAULT      = 8'h1f;
  // reset values and writable masks
  localparam logic [7:0] ENABLE_RST      = 8'h1f;
  localparam logic [7:0] SETUP_RST       = 8'h01;
  localparam logic [7:0] ZERO_RST        = 8'h00;
  localparam logic [7:0] ENABLE_MASK     = 8'h1f;
  localparam logic [7:0] SETUP_MASK      = 8'h13;
  localparam logic [7:0] LOWER_MASK      = 8'h0f;
  localparam logic [7:0] FS_MASK         = 8'h03;
  // field positions
  localparam int         EN_CHIP_BIT     = 0;
  localparam int         EN_STR_LSB      = 1;
  localparam int         SETUP_RAMP_BIT  = 4;
  localparam int         SOFT_RST_BIT    = 0;
  localparam logic [1:0] MODE_REG        = 2'h0;
  localparam logic [1:0] MODE_PWM        = 2'h1;
  // code bands and current shaping
  localparam logic [11:0] CODE_LIN_MIN   = 12'h100;
  localparam logic [11:0] CODE_PULSE_MIN = 12'h010;
  localparam logic [11:0] CODE_MAX       = 12'hfff;
  localparam logic [11:0] PWM_CODE_FULL  = 12'h800;
  localparam logic [10:0] AMP_PULSE_MAX  = 11'h080;
  localparam logic [8:0]  DUTY_FULL      = 9'h100;
  localparam logic [8:0]  DUTY_LOW       = 9'h010;
  localparam int          PWM_CODE_BITS  = 11;
  localparam int          DUTY_WIN_LOG2  = 14;
  // ramp timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int RAMP_FAST_NS  = 128000;
  localparam int RAMP_SLOW_NS  = 1024000;
  localparam int RAMP_FAST_CYC = RAMP_FAST_NS / CLK_PERIOD_NS;
  localparam int RAMP_SLOW_CYC = RAMP_SLOW_NS / CLK_PERIOD_NS;
  // synchronised pin order and idle levels
  localparam int         PIN_SCL  = 0;
  localparam int         PIN_SDA  = 1;
  localparam int         PIN_HARDWARE_ENABLE_PIN = 2;
  localparam int         PIN_PWM  = 3;
  localparam logic [3:0] PIN_RST  = 4'h3;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_AACK, ST_REG, ST_RACK, ST_WDAT, ST_WACK, ST_RDAT, ST_MACK
  } bbc_i2c_state_t;
endpackage

// file: src/bbc_top.sv
// backlight brightness control: serial registers, mode mixing, ramp, current mapping
`timescale 1ns/100ps
`default_nettype none
module bbc_top
  import bbc_pkg::*;
#(
  parameter int P_RAMP_FAST_CYC = RAMP_FAST_CYC,
  parameter int P_RAMP_SLOW_CYC = RAMP_SLOW_CYC,
  parameter int P_DUTY_SHIFT    = DUTY_WIN_LOG2
)(
  input  wire logic        i_mclk,
  input  wire logic        i_reset,
  input  wire logic        i_hardware_enable_pin,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  input  wire logic        i_pwm,
  input  wire logic [7:0]  i_fault_flags,
  output logic             o_sda,
  output logic             o_sda_en_n,
  output logic      [3:0]  o_string_sink_en,
  output logic      [11:0] o_brightness_code,
  output logic      [10:0] o_sink_amplitude,
  output logic             o_sink_gate,
  output logic      [1:0]  o_current_range,
  output logic             o_active,
  output logic             o_shutdown
);
  logic [3:0]     pins;
  logic           scl_prev_ff;
  logic           sda_prev_ff;
  bbc_i2c_state_t state_ff, nxt_state;
  logic [3:0]     cnt_ff, nxt_cnt;
  logic [7:0]     sr_ff, nxt_sr;
  logic [7:0]     tx_ff, nxt_tx;
  logic [7:0]     ptr_ff, nxt_ptr;
  logic           rw_ff, nxt_rw;
  logic           nack_ff, nxt_nack;
  logic           drv_ff, nxt_drv;
  logic [7:0]     enable_ff;
  logic [7:0]     setup_ff;
  logic [7:0]     upper_ff;
  logic [7:0]     lower_ff;
  logic [7:0]     full_scale_ff;
  logic [11:0]    i2c_code_ff;
  logic [11:0]    pwm_code;
  logic [11:0]    eff_code_ff;
  logic [17:0]    step_cnt_ff;
  logic [7:0]     phase_ff;

  // pin conditioning
  bbc_pin_sync u_sync (
    .i_mclk  (i_mclk),
    .i_reset (i_reset),
    .i_pins  ({i_pwm, i_hardware_enable_pin, i_sda, i_scl}),
    .o_pins  (pins)
  );

  wire hardware_enable_pin      = pins[PIN_HARDWARE_ENABLE_PIN];
  wire scl       = pins[PIN_SCL];
  wire sda       = pins[PIN_SDA];
  wire scl_rise  = scl & ~scl_prev_ff;
  wire scl_fall  = ~scl & scl_prev_ff;
  wire bus_start = scl & scl_prev_ff & sda_prev_ff & ~sda;
  wire bus_stop  = scl & scl_prev_ff & ~sda_prev_ff & sda;
  wire byte_full = (cnt_ff == BYTE_BITS);

  // register read mux; reserved bits already masked at write time
  function automatic logic [7:0] read_reg(input logic [7:0] addr);
    case (addr)
      ADDR_ENABLE:     read_reg = enable_ff;
      ADDR_SETUP:      read_reg = setup_ff;
      ADDR_UPPER:      read_reg = upper_ff;
      ADDR_LOWER:      read_reg = lower_ff;
      ADDR_FULL_SCALE: read_reg = full_scale_ff;
      ADDR_FAULT:      read_reg = i_fault_flags;
      default:         read_reg = ZERO_RST;
    endcase
  endfunction

  logic [7:0] rd_now;
  logic [7:0] rd_next;

  // serial slave: sample on scl rise, change sda on scl fall
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_sr    = sr_ff;
    nxt_tx    = tx_ff;
    nxt_ptr   = ptr_ff;
    nxt_rw    = rw_ff;
    nxt_nack  = nack_ff;
    nxt_drv   = drv_ff;
    rd_now    = read_reg(ptr_ff); // inside the process so register changes wake it
    rd_next   = read_reg(ptr_ff + 8'h01);
    if (!hardware_enable_pin)
    begin
      nxt_state = ST_IDLE;
      nxt_drv   = 1'b1;
    end
    else if (bus_start)
    begin
      nxt_state = ST_ADDR;
      nxt_cnt   = '0;
      nxt_drv   = 1'b1;
    end
    else if (bus_stop)
    begin
      nxt_state = ST_IDLE;
      nxt_drv   = 1'b1;
    end
    else if (scl_rise && state_ff != ST_IDLE)
    begin
      nxt_sr  = {sr_ff[6:0], sda};
      nxt_cnt = cnt_ff + 4'h1;
      if (state_ff == ST_MACK)
        nxt_nack = sda;
    end
    else if (scl_fall)
    begin
      case (state_ff)
        ST_IDLE: nxt_state = ST_IDLE;
        ST_ADDR:
          if (byte_full)
          begin
            if (sr_ff[7:1] == DEV_ADDR)
            begin
              nxt_state = ST_AACK;
              nxt_rw    = sr_ff[0];
              nxt_drv   = 1'b0;
            end
            else
              nxt_state = ST_IDLE;
          end
        ST_AACK:
        begin
          nxt_cnt = '0;
          if (rw_ff)
          begin
            nxt_state = ST_RDAT;
            nxt_tx    = {rd_now[6:0], 1'b0};
            nxt_drv   = rd_now[7];
          end
          else
          begin
            nxt_state = ST_REG;
            nxt_drv   = 1'b1;
          end
        end
        ST_REG:
          if (byte_full)
          begin
            nxt_ptr   = sr_ff;
            nxt_state = ST_RACK;
            nxt_drv   = 1'b0;
          end
        ST_RACK, ST_WACK:
        begin
          if (state_ff == ST_WACK)
            nxt_ptr = ptr_ff + 8'h01;
          nxt_state = ST_WDAT;
          nxt_drv   = 1'b1;
          nxt_cnt   = '0;
        end
        ST_WDAT:
          if (byte_full)
          begin
            nxt_state = ST_WACK;
            nxt_drv   = 1'b0;
          end
        ST_RDAT:
          if (byte_full)
          begin
            nxt_state = ST_MACK;
            nxt_drv   = 1'b1;
            nxt_cnt   = '0;
          end
          else
          begin
            nxt_drv = tx_ff[7];
            nxt_tx  = {tx_ff[6:0], 1'b0};
          end
        ST_MACK:
          if (nack_ff)
          begin
            nxt_state = ST_IDLE;
            nxt_drv   = 1'b1;
          end
          else
          begin
            nxt_ptr   = ptr_ff + 8'h01;
            nxt_tx    = {rd_next[6:0], 1'b0};
            nxt_drv   = rd_next[7];
            nxt_state = ST_RDAT;
            nxt_cnt   = '0;
          end
        default: nxt_state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
      state_ff    <= ST_IDLE;
      cnt_ff      <= '0;
      sr_ff       <= '0;
      tx_ff       <= '0;
      ptr_ff      <= '0;
      rw_ff       <= 1'b0;
      nack_ff     <= 1'b0;
      drv_ff      <= 1'b1;
      o_sda       <= 1'b1;
      o_sda_en_n  <= 1'b1;
    end
    else
    begin
      scl_prev_ff <= scl;
      sda_prev_ff <= sda;
      state_ff    <= nxt_state;
      cnt_ff      <= nxt_cnt;
      sr_ff       <= nxt_sr;
      tx_ff       <= nxt_tx;
      ptr_ff      <= nxt_ptr;
      rw_ff       <= nxt_rw;
      nack_ff     <= nxt_nack;
      drv_ff      <= nxt_drv;
      o_sda       <= nxt_drv;
      o_sda_en_n  <= nxt_drv; // open drain: only a low is driven
    end
  end

  // write decode; the fault address has no write path at all
  wire wr_stb    = hardware_enable_pin & scl_fall & (state_ff == ST_WDAT) & byte_full;
  wire wr_enable = wr_stb & (ptr_ff == ADDR_ENABLE);
  wire wr_setup  = wr_stb & (ptr_ff == ADDR_SETUP);
  wire wr_upper  = wr_stb & (ptr_ff == ADDR_UPPER);
  wire wr_lower  = wr_stb & (ptr_ff == ADDR_LOWER);
  wire wr_fs     = wr_stb & (ptr_ff == ADDR_FULL_SCALE);
  wire soft_rst  = wr_stb & (ptr_ff == ADDR_SOFT_RESET) & sr_ff[SOFT_RST_BIT];
  wire clr_regs  = ~hardware_enable_pin | soft_rst;

  // register file; values survive standby, only shutdown or a soft reset clears them
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      enable_ff     <= ENABLE_RST;
      setup_ff      <= SETUP_RST;
      upper_ff      <= ZERO_RST;
      lower_ff      <= ZERO_RST;
      full_scale_ff <= ZERO_RST;
      i2c_code_ff   <= '0;
    end
    else if (clr_regs)
    begin
      enable_ff     <= ENABLE_RST;
      setup_ff      <= SETUP_RST;
      upper_ff      <= ZERO_RST;
      lower_ff      <= ZERO_RST;
      full_scale_ff <= ZERO_RST;
      i2c_code_ff   <= '0;
    end
    else
    begin
      if (wr_enable)
        enable_ff <= sr_ff & ENABLE_MASK;
      if (wr_setup)
        setup_ff <= sr_ff & SETUP_MASK;
      if (wr_lower)
        lower_ff <= sr_ff & LOWER_MASK;
      if (wr_fs)
        full_scale_ff <= sr_ff & FS_MASK;
      if (wr_upper)
      begin
        upper_ff    <= sr_ff;
        i2c_code_ff <= {sr_ff, lower_ff[3:0]};
      end
    end
  end

  // mode selection and mixing
  wire [1:0] mode    = setup_ff[1:0];
  wire       pwm_run = hardware_enable_pin & (mode != MODE_REG);

  bbc_duty_meter #(
    .P_SHIFT (P_DUTY_SHIFT)
  ) u_duty (
    .i_mclk  (i_mclk),
    .i_reset (i_reset),
    .i_run   (pwm_run),
    .i_pwm   (pins[PIN_PWM]),
    .o_code  (pwm_code)
  );

  wire [11:0] tgt_pwm = (pwm_code >= PWM_CODE_FULL) ? CODE_MAX : {pwm_code[10:0], 1'b0};
  wire [23:0] mix     = {i2c_code_ff[11:1], 1'b0} * pwm_code;
  wire [11:0] target  = (mode == MODE_REG) ? i2c_code_ff :
                        (mode == MODE_PWM) ? tgt_pwm : mix[22:11];

  // ramp: pwm-only mode never ramps
  wire        ramp_on  = setup_ff[SETUP_RAMP_BIT] & (mode != MODE_PWM);
  wire [17:0] step_len = (upper_ff[7:4] != 4'h0) ? 18'(P_RAMP_FAST_CYC - 1) : 18'(P_RAMP_SLOW_CYC - 1);
  wire        moving   = ramp_on & (eff_code_ff != target);
  wire        step     = moving & (step_cnt_ff >= step_len);
  wire [11:0] eff_step = (target > eff_code_ff) ? eff_code_ff + 12'h001 : eff_code_ff - 12'h001;

  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      step_cnt_ff <= '0;
      eff_code_ff <= '0;
    end
    else
    begin
      step_cnt_ff <= (!moving || step) ? '0 : step_cnt_ff + 18'h0_0001;
      if (!hardware_enable_pin)
        eff_code_ff <= '0;
      else if (!ramp_on)
        eff_code_ff <= target;
      else if (step)
        eff_code_ff <= eff_step;
    end
  end

  // exponential low band, amplitude 16x the average
  function automatic logic [10:0] low_amp(input logic [3:0] c);
    case (c)
      4'h1: low_amp = 11'h010;
      4'h2: low_amp = 11'h012;
      4'h3: low_amp = 11'h015;
      4'h4: low_amp = 11'h018;
      4'h5: low_amp = 11'h01c;
      4'h6: low_amp = 11'h020;
      4'h7: low_amp = 11'h025;
      4'h8: low_amp = 11'h02a;
      4'h9: low_amp = 11'h031;
      4'ha: low_amp = 11'h038;
      4'hb: low_amp = 11'h040;
      4'hc: low_amp = 11'h04a;
      4'hd: low_amp = 11'h055;
      4'he: low_amp = 11'h061;
      4'hf: low_amp = 11'h070;
      default: low_amp = 11'h000;
    endcase
  endfunction

  // code to amplitude and duty (units of the least current step)
  wire        band_lin   = (eff_code_ff >= CODE_LIN_MIN);
  wire        band_pulse = (eff_code_ff >= CODE_PULSE_MIN);
  wire [10:0] map_amp    = band_lin ? eff_code_ff[11:1] :
                           band_pulse ? AMP_PULSE_MAX : low_amp(eff_code_ff[3:0]);
  wire [8:0]  map_duty   = band_lin ? DUTY_FULL :
                           band_pulse ? {1'b0, eff_code_ff[7:1], 1'b0} :
                           (eff_code_ff != '0) ? DUTY_LOW : 9'h000;
  wire        active     = hardware_enable_pin & enable_ff[EN_CHIP_BIT] & (|enable_ff[4:1]) & (eff_code_ff != '0);

  // outputs all registered; strings off in standby to save current
  always_ff @(posedge i_mclk or posedge i_reset)
  begin
    if (i_reset)
    begin
      phase_ff          <= '0;
      o_string_sink_en  <= '0;
      o_brightness_code <= '0;
      o_sink_amplitude  <= '0;
      o_sink_gate       <= 1'b0;
      o_current_range   <= '0;
      o_active          <= 1'b0;
      o_shutdown        <= 1'b1;
    end
    else
    begin
      phase_ff          <= phase_ff + 8'h01;
      o_string_sink_en  <= active ? enable_ff[4:1] : 4'h0;
      o_brightness_code <= eff_code_ff;
      o_sink_amplitude  <= active ? map_amp : 11'h000;
      o_sink_gate       <= active & ({1'b0, phase_ff} < map_duty);
      o_current_range   <= full_scale_ff[1:0];
      o_active          <= active;
      o_shutdown        <= ~hardware_enable_pin;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  sequence s_lower_write;
    wr_lower;
  endsequence
  sequence s_upper_write;
    wr_upper ##1 1'b1;
  endsequence

  a_shutdown_defaults: assert property (!hardware_enable_pin |=> enable_ff == ENABLE_RST && setup_ff == SETUP_RST)
    else $error("registers not at default in shutdown");
  a_shutdown_quiet: assert property (!hardware_enable_pin |=> ##1 o_sda_en_n && !o_active)
    else $error("device active or driving bus in shutdown");
  a_lower_held: assert property (s_lower_write |=> $stable(i2c_code_ff))
    else $error("lower nibble changed code before upper write");
  a_upper_commits: assert property (s_upper_write |-> i2c_code_ff == {$past(sr_ff), $past(lower_ff[3:0])})
    else $error("upper write did not form code");
  a_reg_mode_target: assert property (mode == MODE_REG |-> target == i2c_code_ff)
    else $error("pwm input leaked into register mode");
  a_zero_dark: assert property (eff_code_ff == '0 |=> o_sink_amplitude == '0 && !o_sink_gate)
    else $error("current flowing at code zero");
  a_linear_amp: assert property (active && band_lin |=> o_sink_gate && o_sink_amplitude == $past(eff_code_ff[11:1]))
    else $error("linear band amplitude wrong");
  a_mid_amp: assert property (active && band_pulse && !band_lin |=> o_sink_amplitude == AMP_PULSE_MAX)
    else $error("pulse band amplitude not fixed");
  a_low_duty: assert property (active && band_pulse == 1'b0 && phase_ff == 8'h10 |=> !o_sink_gate)
    else $error("low band duty exceeds 16/256");
  a_ramp_step: assert property (hardware_enable_pin && ramp_on |=>
                                (eff_code_ff == $past(eff_code_ff) || eff_code_ff == $past(eff_step)))
    else $error("ramp moved more than one step");
  a_string_off: assert property (!active |=> o_string_sink_en == 4'h0)
    else $error("strings enabled in standby");
endmodule
`default_nettype wire

// file: verif/backlight_brightness_control_tb.sv
// self-checking bench for the backlight brightness control block
`timescale 1ns/100ps
`default_nettype none
module backlight_brightness_control_tb
  import bbc_pkg::*;
;
  localparam int LIMIT = 80000;
  logic        mclk;
  logic        reset;
  logic        hardware_enable_pin;
  logic        pwm;
  logic [7:0]  fault;
  logic        scl;
  logic        sda;
  logic        sda_en_n;
  logic        sda_drv;
  logic [3:0]  sink_en;
  logic [11:0] code;
  logic [10:0] amp;
  logic        gate;
  logic [1:0]  range;
  logic        active;
  logic        shutdown;
  int          bad_count;
  int          n_compared;
  int          cycles;
  bbc_host_model #(.P_HALF(12)) i_host (.i_mclk(mclk), .i_sda_en_n(sda_en_n), .o_scl(scl), .o_sda(sda));
  // short ramp and duty window counts keep the run brief
  bbc_top #(.P_RAMP_FAST_CYC(8), .P_RAMP_SLOW_CYC(16), .P_DUTY_SHIFT(6)) i_dut (
    .i_mclk(mclk), .i_reset(reset), .i_hardware_enable_pin(hardware_enable_pin), .i_scl(scl), .i_sda(sda), .i_pwm(pwm),
    .i_fault_flags(fault), .o_sda(sda_drv), .o_sda_en_n(sda_en_n), .o_string_sink_en(sink_en),
    .o_brightness_code(code), .o_sink_amplitude(amp), .o_sink_gate(gate), .o_current_range(range),
    .o_active(active), .o_shutdown(shutdown));
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // a hang counts as a mismatch
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic check(input string name, input logic [11:0] exp, input logic [11:0] got);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic nak;
    i_host.write_reg(DEV_ADDR, a, d, nak);
    check("write ack", 12'h000, 12'(nak));
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    logic       nak;
    i_host.read_reg(a, q, nak);
    check("read ack", 12'h000, 12'(nak));
    check($sformatf("reg %h", a), 12'(exp), 12'(q));
  endtask
  // any 256 cycles span exactly one gate period
  task automatic gate_high(input logic [11:0] exp);
    logic [11:0] n;
    n = 12'h000;
    repeat (256)
    begin
      cyc(1);
      n = n + 12'(gate);
    end
    check("gate high cycles", exp, n);
  endtask
  task automatic t_defaults();
    logic nak;
    check("shutdown", 12'h000, 12'(shutdown));
    rd(ADDR_ENABLE, 8'h1f);
    rd(ADDR_SETUP, 8'h01);
    wr(ADDR_FAULT, 8'h00);
    rd(ADDR_FAULT, fault);
    i_host.write_reg(DEV_ADDR ^ 7'h01, ADDR_SETUP, 8'h00, nak);
    check("foreign address nak", 12'h001, 12'(nak));
    $display("test defaults done");
  endtask
  task automatic t_pwm();
    cyc(300);
    check("standby active", 12'h000, 12'(active));
    check("zero amplitude", 12'h000, 12'(amp));
    pwm = 1'b1;
    cyc(300);
    check("pwm code", 12'hfff, code);
    check("pwm amplitude", 12'h7ff, 12'(amp));
    check("strings", 12'h00f, 12'(sink_en));
    $display("test pwm done");
  endtask
  task automatic t_reg_mode();
    wr(ADDR_SETUP, 8'h00);
    wr(ADDR_LOWER, 8'h05);
    check("held lower", 12'h000, code);
    wr(ADDR_UPPER, 8'ha5);
    check("joined code", 12'ha55, code);
    check("linear amplitude", 12'h52a, 12'(amp));
    pwm = 1'b0;
    cyc(300);
    check("pwm ignored", 12'ha55, code);
    gate_high(12'h100);
    $display("test register mode done");
  endtask
  task automatic t_low();
    wr(ADDR_UPPER, 8'h02);
    check("pulse amplitude", 12'h080, 12'(amp));
    gate_high(12'h024);
    wr(ADDR_UPPER, 8'h00);
    check("low amplitude", 12'h01c, 12'(amp));
    gate_high(12'h010);
    wr(ADDR_LOWER, 8'h00);
    wr(ADDR_UPPER, 8'h00);
    check("zero code amplitude", 12'h000, 12'(amp));
    gate_high(12'h000);
    $display("test low bands done");
  endtask
  task automatic t_ramp();
    logic [11:0] c0;
    wr(ADDR_UPPER, 8'h10);
    wr(ADDR_SETUP, 8'h10);
    wr(ADDR_UPPER, 8'h12);
    c0 = code;
    cyc(40);
    check("fast ramp steps", c0 + 12'h005, code);
    cyc(300);
    check("ramp end", 12'h120, code);
    wr(ADDR_UPPER, 8'h01);
    c0 = code;
    cyc(160);
    check("slow ramp steps", c0 - 12'h00a, code);
    wr(ADDR_SETUP, 8'h00);
    $display("test ramp done");
  endtask
  task automatic t_strings();
    wr(ADDR_UPPER, 8'ha5);
    wr(ADDR_ENABLE, 8'h05);
    check("one string", 12'h002, 12'(sink_en));
    wr(ADDR_FULL_SCALE, 8'hff);
    rd(ADDR_FULL_SCALE, 8'h03);
    check("range", 12'h003, 12'(range));
    wr(ADDR_ENABLE, 8'h1e);
    check("chip off", 12'h000, 12'(active));
    rd(ADDR_UPPER, 8'ha5);
    wr(ADDR_ENABLE, 8'h1f);
    check("chip on", 12'h001, 12'(active));
    $display("test strings done");
  endtask
  // combined mode: full duty keeps the register code, zero duty darkens
  task automatic t_mixed();
    wr(ADDR_SETUP, 8'h02);
    pwm = 1'b1;
    cyc(300);
    check("mixed full duty", 12'ha50, code);
    pwm = 1'b0;
    cyc(300);
    check("mixed zero duty", 12'h000, code);
    $display("test mixed mode done");
  endtask
  task automatic t_disable();
    logic nak;
    hardware_enable_pin = 1'b0;
    cyc(20);
    check("shutdown", 12'h001, 12'(shutdown));
    check("sinks off", 12'h000, 12'(sink_en));
    check("sda released", 12'h001, 12'(sda_drv));
    i_host.write_reg(DEV_ADDR, ADDR_SETUP, 8'h00, nak);
    check("bus ignored", 12'h001, 12'(nak));
    hardware_enable_pin = 1'b1;
    cyc(20);
    check("running", 12'h000, 12'(shutdown));
    rd(ADDR_FULL_SCALE, 8'h00);
    rd(ADDR_UPPER, 8'h00);
    rd(ADDR_SETUP, 8'h01);
    $display("test disable done");
  endtask
  initial
  begin
    bad_count = 0;
    n_compared = 0;
    cycles = 0;
    reset = 1'b1;
    hardware_enable_pin = 1'b1;
    pwm = 1'b0;
    fault = 8'h5a;
    repeat (6) @(posedge mclk);
    #1;
    reset = 1'b0;
    cyc(10);
    t_defaults();
    t_pwm();
    t_reg_mode();
    t_low();
    t_ramp();
    t_strings();
    t_mixed();
    t_disable();
    report_and_stop();
  end
endmodule
`default_nettype wire

// file: verif/bbc_host_model.sv
// serial host model that reaches the block's registers over the two-wire bus
`timescale 1ns/100ps
`default_nettype none
module bbc_host_model
  import bbc_pkg::*;
#(
  parameter int P_HALF = 12
)(
  input  wire logic i_mclk,
  input  wire logic i_sda_en_n,
  output logic      o_scl,
  output logic      o_sda
);
  logic scl_q;
  logic sda_rel;
  // data line has a pull-up: low while either party pulls it
  assign o_scl = scl_q;
  assign o_sda = sda_rel & i_sda_en_n;
  initial
  begin
    scl_q = 1'b1;
    sda_rel = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  // data moves a few cycles after the clock fall, never together with it
  task automatic start();
    wt(4);
    sda_rel = 1'b1;
    wt(P_HALF);
    scl_q = 1'b1;
    wt(P_HALF);
    sda_rel = 1'b0;
    wt(P_HALF);
    scl_q = 1'b0;
  endtask
  task automatic stop();
    wt(4);
    sda_rel = 1'b0;
    wt(P_HALF);
    scl_q = 1'b1;
    wt(P_HALF);
    sda_rel = 1'b1;
    wt(P_HALF);
  endtask
  task automatic xfer_bit(input logic b, output logic got);
    wt(4);
    sda_rel = b;
    wt(P_HALF);
    scl_q = 1'b1;
    wt(P_HALF);
    got = o_sda;
    scl_q = 1'b0;
  endtask
  // eight bits then a released ninth bit for the acknowledge
  task automatic xfer_byte(input logic [7:0] d, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--)
      xfer_bit(d[i], q[i]);
    xfer_bit(1'b1, ack);
  endtask
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d, output logic nak);
    logic [7:0] q;
    logic       k0;
    logic       k1;
    logic       k2;
    start();
    xfer_byte({dev, 1'b0}, q, k0);
    xfer_byte(a, q, k1);
    xfer_byte(d, q, k2);
    stop();
    nak = k0 | k1 | k2;
  endtask
  // single-byte read: the host's released ninth bit ends it
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic nak);
    logic [7:0] q;
    logic       k0;
    logic       k1;
    logic       k2;
    logic       k3;
    start();
    xfer_byte({DEV_ADDR, 1'b0}, q, k0);
    xfer_byte(a, q, k1);
    start();
    xfer_byte({DEV_ADDR, 1'b1}, q, k2);
    xfer_byte(8'hff, d, k3);
    stop();
    nak = k0 | k1 | k2;
  endtask
endmodule
`default_nettype wire
